// ---- rtl/lpc_defines.svh ----
// Bit positions, widths and reset values for the printer command and status port
`ifndef LPC_DEFINES_SVH
`define LPC_DEFINES_SVH
// Bus bit n of the 36-bit word sits at vector index 35-n
`define LPC_WORD_W      36
`define LPC_CO_INIT     10
`define LPC_BIT_ERROR   8
`define LPC_BIT_BUSY    7
`define LPC_BIT_DONE    6
`define LPC_ERR_LVL_HI  5
`define LPC_ERR_LVL_LO  3
`define LPC_CMP_LVL_HI  2
`define LPC_CMP_LVL_LO  0
`define LPC_CHAR_W      7
`define LPC_CHARS       5
`define LPC_PI_LINES    7
`define LPC_LEVEL_RST   3'h0
`define LPC_LEFT_FULL   3'h5
`endif

// ---- rtl/lpc_pkg.sv ----
// Types shared by the printer command and status port
package lpc_pkg;
	typedef logic [6:0] lpc_char_type;
	typedef logic [2:0] lpc_level_type;
	typedef logic [2:0] lpc_count_type;
endpackage

// ---- rtl/lpc_port.sv ----
// Bus command and status port of a line printer controller
`include "lpc_defines.svh"

// Function
// - Act on three instructions; ignore data-in read
// - Initialize bit empties the character buffer
// - Busy bit in control word sets busy
// - Done bit in control word sets done
// - Store error interrupt level from control word
// - Store completion interrupt level from control word
// - Control word can clear flags, empty buffer
// - Data write loads five characters, busy, clears done
// - Status read drives current status onto bus
// - Status word: error, busy, done, both levels
// - Next character waits for free printer slot
// - All five drained raises completion
module lpc_port (
	input  wire logic                   clk,
	input  wire logic                   rstn,
	input  wire logic                   clk_en,
	input  wire logic                   dev_select,
	input  wire logic                   condition_out_write,
	input  wire logic                   condition_in_read,
	input  wire logic                   data_out_write,
	input  wire logic                   data_in_read,
	input  wire logic [35:0]            bus_data_in,
	output logic      [35:0]            bus_data_out,
	output logic                        bus_data_oe,
	output logic      [7:1]             pi_request,
	output lpc_pkg::lpc_char_type       char_data,
	output logic                        char_valid,
	input  wire logic                   character_slot_free,
	input  wire logic                   printer_error,
	output logic                        printer_error_flag
);
	logic                    rst_q1;      // Reset release stage one
	logic                    rst_q2;      // Reset release stage two
	logic                    busy;        // Controller busy
	logic                    done;        // Controller done
	lpc_pkg::lpc_level_type  err_lvl;     // Error interrupt level
	lpc_pkg::lpc_level_type  cmp_lvl;     // Completion interrupt level
	logic [34:0]             char_sreg;   // Character buffer, first char on top
	lpc_pkg::lpc_count_type  chars_left;  // Characters not yet moved out
	lpc_pkg::lpc_char_type   ent1;        // Second buffer entry
	logic                    vld1;        // Second entry valid
	logic                    do_condition_out_write;     // Control word this cycle
	logic                    do_condition_in_read;     // Status read this cycle
	logic                    do_data_out_write;    // Data word this cycle
	logic                    do_init;     // Initialize request
	logic                    flush;       // Empty all buffered characters
	logic                    push;        // Character enters the buffer
	logic                    pop;         // Printer takes a character
	logic                    drained;     // Last character handed over
	logic [35:0]             status;      // Assembled status word
	logic [7:1]              next_pi;     // Request lines before the register
	logic                    loaded;      // A data word is still being worked off

	// Reset is released through two flip-flops
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rst_q1 <= 1'b0;
			rst_q2 <= 1'b0;
		end else begin
			rst_q1 <= 1'b1;
			rst_q2 <= rst_q1;
		end
	end

	// Instruction decode, gated by select and clock enable
	always_comb begin
		do_condition_out_write  = clk_en && dev_select && condition_out_write;
		do_condition_in_read  = clk_en && dev_select && condition_in_read;
		do_data_out_write = clk_en && dev_select && data_out_write;
		do_init  = do_condition_out_write && bus_data_in[`LPC_CO_INIT];
		// Clearing busy also empties the buffer
		flush    = do_init || (do_condition_out_write && !bus_data_in[`LPC_BIT_BUSY]);
		pop      = clk_en && char_valid && character_slot_free;
		push     = clk_en && busy && (chars_left != 3'h0) && !vld1 && !flush && !do_data_out_write;
		// Only a data word can drain, so busy set by a control word alone stays
		drained  = loaded && busy && (chars_left == 3'h0) && !char_valid && !vld1;
	end

	// Busy flag: data write sets, control word loads, drain clears
	always_ff @(posedge clk or negedge rst_q2) begin
		if (!rst_q2) begin
			busy <= 1'b0;
		end else if (do_data_out_write) begin
			busy <= 1'b1;
		end else if (do_condition_out_write) begin
			busy <= bus_data_in[`LPC_BIT_BUSY];
		end else if (clk_en && drained) begin
			busy <= 1'b0;
		end
	end

	// Data word in progress: set by a data write, ended by flush or drain
	always_ff @(posedge clk or negedge rst_q2) begin
		if (!rst_q2) begin
			loaded <= 1'b0;
		end else if (do_data_out_write) begin
			loaded <= 1'b1;
		end else if (flush) begin
			loaded <= 1'b0;
		end else if (clk_en && drained) begin
			loaded <= 1'b0;
		end
	end

	// Done flag: completion set wins over a clearing control word
	always_ff @(posedge clk or negedge rst_q2) begin
		if (!rst_q2) begin
			done <= 1'b0;
		end else if (do_data_out_write) begin
			done <= 1'b0;
		end else if (clk_en && drained) begin
			done <= 1'b1;
		end else if (do_condition_out_write) begin
			done <= bus_data_in[`LPC_BIT_DONE];
		end
	end

	// Interrupt levels from each control word
	always_ff @(posedge clk or negedge rst_q2) begin
		if (!rst_q2) begin
			err_lvl <= `LPC_LEVEL_RST;
			cmp_lvl <= `LPC_LEVEL_RST;
		end else if (do_condition_out_write) begin
			err_lvl <= bus_data_in[`LPC_ERR_LVL_HI:`LPC_ERR_LVL_LO];
			cmp_lvl <= bus_data_in[`LPC_CMP_LVL_HI:`LPC_CMP_LVL_LO];
		end
	end

	// Character buffer register, shifted one character per push
	always_ff @(posedge clk or negedge rst_q2) begin
		if (!rst_q2) begin
			char_sreg  <= 35'h0;
			chars_left <= 3'h0;
		end else if (do_data_out_write) begin
			char_sreg  <= bus_data_in[35:1];
			chars_left <= `LPC_LEFT_FULL;
		end else if (flush) begin
			char_sreg  <= 35'h0;
			chars_left <= 3'h0;
		end else if (push) begin
			char_sreg  <= {char_sreg[27:0], 7'h00};
			chars_left <= chars_left - 3'h1;
		end
	end

	// Two-entry buffer toward the printer; head drives the outputs
	always_ff @(posedge clk or negedge rst_q2) begin
		if (!rst_q2) begin
			char_data  <= 7'h00;
			char_valid <= 1'b0;
			ent1       <= 7'h00;
			vld1       <= 1'b0;
		end else if (flush || do_data_out_write) begin
			// New word or flush drops anything still queued
			char_valid <= 1'b0;
			vld1       <= 1'b0;
		end else if (pop) begin
			// Head leaves; refill from second entry or the shifter
			char_data  <= vld1 ? ent1 : char_sreg[34:28];
			char_valid <= vld1 || push;
			if (vld1 && push) begin
				ent1 <= char_sreg[34:28];
			end
			vld1 <= vld1 && push;
		end else if (push) begin
			if (!char_valid) begin
				char_data  <= char_sreg[34:28];
				char_valid <= 1'b1;
			end else begin
				ent1 <= char_sreg[34:28];
				vld1 <= 1'b1;
			end
		end
	end

	// Printer error follows the printer's own report
	always_ff @(posedge clk or negedge rst_q2) begin
		if (!rst_q2) begin
			printer_error_flag <= 1'b0;
		end else if (clk_en) begin
			printer_error_flag <= printer_error;
		end
	end

	// Status word assembly
	always_comb begin
		status = 36'h0;
		status[`LPC_BIT_ERROR] = printer_error_flag;
		status[`LPC_BIT_BUSY]  = busy;
		status[`LPC_BIT_DONE]  = done;
		status[`LPC_ERR_LVL_HI:`LPC_ERR_LVL_LO] = err_lvl;
		status[`LPC_CMP_LVL_HI:`LPC_CMP_LVL_LO] = cmp_lvl;
	end

	// Status read answer; data-in read gets nothing
	always_ff @(posedge clk or negedge rst_q2) begin
		if (!rst_q2) begin
			bus_data_out <= 36'h0;
			bus_data_oe  <= 1'b0;
		end else if (clk_en) begin
			bus_data_out <= do_condition_in_read ? status : 36'h0;
			bus_data_oe  <= do_condition_in_read;
		end
	end

	// One request line per nonzero level, 1 to 7; level 0 drives none
	genvar gi;
	generate
		for (gi = 1; gi <= `LPC_PI_LINES; gi++) begin : g_pi
			always_comb begin
				next_pi[gi] = (done && (cmp_lvl == 3'(gi))) ||
					(printer_error_flag && (err_lvl == 3'(gi)));
			end
		end
	endgenerate

	// Request lines registered
	always_ff @(posedge clk or negedge rst_q2) begin
		if (!rst_q2) begin
			pi_request <= 7'h00;
		end else if (clk_en) begin
			pi_request <= next_pi;
		end
	end

	// Checks on the port behaviour
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_q2);

	// Buffer fully emptied with no command pending
	sequence s_drained;
		clk_en && drained && !do_data_out_write && !do_condition_out_write;
	endsequence

	// Printer holding off a waiting character
	sequence s_stall;
		char_valid && !character_slot_free && !flush && !do_data_out_write;
	endsequence

	a_data_out_write_loads_five: assert property (do_data_out_write |=>
		busy && !done && chars_left == 3'h5)
		else $error("data write did not load five characters");
	a_init_flushes: assert property (do_init |=>
		!char_valid && !vld1 && chars_left == 3'h0)
		else $error("initialize left characters queued");
	a_condition_out_write_sets_busy: assert property (do_condition_out_write && !do_data_out_write &&
		bus_data_in[`LPC_BIT_BUSY] |=> busy)
		else $error("busy not set by control word");
	a_condition_out_write_sets_done: assert property (do_condition_out_write && !do_data_out_write &&
		bus_data_in[`LPC_BIT_DONE] |=> done)
		else $error("done not set by control word");
	a_err_level_store: assert property (do_condition_out_write |=>
		err_lvl == $past(bus_data_in[5:3]))
		else $error("error level not stored");
	a_cmp_level_store: assert property (do_condition_out_write |=>
		cmp_lvl == $past(bus_data_in[2:0]))
		else $error("completion level not stored");
	a_busy_clear_flush: assert property (do_condition_out_write && !do_data_out_write &&
		!bus_data_in[`LPC_BIT_BUSY] |=>
		!char_valid && chars_left == 3'h0)
		else $error("clearing busy did not empty buffer");
	a_status_word: assert property (do_condition_in_read |=> bus_data_oe &&
		bus_data_out[7] == $past(busy) && bus_data_out[6] == $past(done) &&
		bus_data_out[5:0] == $past({err_lvl, cmp_lvl}))
		else $error("status word wrong");
	a_data_in_read_silent: assert property (clk_en && !do_condition_in_read |=> !bus_data_oe)
		else $error("bus driven without status read");
	a_slot_wait: assert property (s_stall |=> char_valid && $stable(char_data))
		else $error("character moved while slot busy");
	a_drain_done: assert property (s_drained |=> done && !busy ##1
		!clk_en || pi_request != 7'h00 || cmp_lvl == 3'h0)
		else $error("completion not raised after drain");
	a_no_level_zero: assert property (clk_en && cmp_lvl == 3'h0 && err_lvl == 3'h0
		&& !do_condition_out_write |=> pi_request == 7'h00)
		else $error("request with zero levels");

	// Control word that sets busy with no data pending keeps busy up
	a_busy_sticks: assert property (do_condition_out_write && !do_data_out_write && bus_data_in[`LPC_BIT_BUSY]
		##1 (clk_en && !loaded && !do_condition_out_write && !do_data_out_write) |=> busy)
		else $error("busy fell without a data word");

	// First character of a data word reaches the head two cycles on
	a_first_char: assert property (do_data_out_write ##1 (clk_en && !flush && !do_data_out_write) |=>
		char_valid && char_data == $past(bus_data_in[35:29], 2))
		else $error("first character not presented");

	// Bus data stays zero whenever the status answer is not enabled
	a_out_zero_idle: assert property (!bus_data_oe |-> bus_data_out == 36'h0)
		else $error("bus data not zero while idle");

	// Error flag is a one-cycle copy of the printer report
	a_err_flag_copy: assert property (clk_en |=>
		printer_error_flag == $past(printer_error))
		else $error("error flag not following printer");

	// Done with a nonzero completion level raises that level's line
	a_pi_done_line: assert property (clk_en && done && cmp_lvl != 3'h0 |=>
		pi_request[$past(cmp_lvl)])
		else $error("completion line not raised");

	// Low clock enable holds flags and queue as they are
	a_freeze_state: assert property (!clk_en |=> $stable(busy) && $stable(done) &&
		$stable(char_valid) && $stable(chars_left))
		else $error("state moved while clock enable low");
endmodule

// ---- tb/lpc_printer_model.sv ----
// Printer side model: takes characters, optionally slow to free its slot
module lpc_printer_model (
	input  wire logic                  clk,
	input  wire logic                  slow,
	input  wire lpc_pkg::lpc_char_type char_data,
	input  wire logic                  char_valid,
	output logic                       character_slot_free
);
	timeunit 1ns;
	timeprecision 1ps;
	lpc_pkg::lpc_char_type got [$]; // Characters taken, in order
	logic [1:0]            wait_cnt; // Busy cycles left after a character
	initial begin
		character_slot_free = 1'b1;
		wait_cnt = 2'h0;
	end
	// Take a character only while the slot is free; slow mode holds it busy
	always @(posedge clk) begin
		if (char_valid === 1'b1 && character_slot_free) begin
			got.push_back(char_data);
			character_slot_free <= !slow;
			wait_cnt <= slow ? 2'h3 : 2'h0;
		end else if (wait_cnt != 2'h0) begin
			wait_cnt <= wait_cnt - 2'h1;
			character_slot_free <= (wait_cnt == 2'h1);
		end
	end
endmodule

// ---- tb/printer_io_bus_command_status_port_bench.sv ----
// Self-checking bench for the printer command and status port
module printer_io_bus_command_status_port_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, rstn, clk_en, dev_select, slow, printer_error;
	logic        condition_out_write, condition_in_read, data_out_write, data_in_read;
	logic [35:0] bus_data_in, bus_data_out;
	logic        bus_data_oe, char_valid, character_slot_free, printer_error_flag;
	logic [7:1]  pi_request;
	lpc_pkg::lpc_char_type char_data;
	int          err_count, n_tests, cycles, n_got;
	logic [15:0] rows [5]; // Error input, control bits 7:0, expected requests
	lpc_port dut (.clk(clk), .rstn(rstn), .clk_en(clk_en), .dev_select(dev_select),
		.condition_out_write(condition_out_write), .condition_in_read(condition_in_read),
		.data_out_write(data_out_write), .data_in_read(data_in_read),
		.bus_data_in(bus_data_in), .bus_data_out(bus_data_out), .bus_data_oe(bus_data_oe),
		.pi_request(pi_request), .char_data(char_data), .char_valid(char_valid),
		.character_slot_free(character_slot_free), .printer_error(printer_error),
		.printer_error_flag(printer_error_flag));
	lpc_printer_model model (.clk(clk), .slow(slow), .char_data(char_data),
		.char_valid(char_valid), .character_slot_free(character_slot_free));
	// 40 MHz clock
	always #12.5 clk = ~clk;
	// Compare one value and count it
	task automatic check(input string what, input logic [35:0] exp, input logic [35:0] got);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	// One-cycle strobe: 0 control, 1 data, 2 status, 3 data-in
	task automatic strobe(input int kind, input logic [35:0] word);
		@(posedge clk);
		bus_data_in <= word;
		condition_out_write <= (kind == 0);
		data_out_write <= (kind == 1);
		condition_in_read <= (kind == 2);
		data_in_read <= (kind == 3);
		@(posedge clk);
		{condition_out_write, data_out_write, condition_in_read, data_in_read} <= 4'h0;
	endtask
	// Status read, answer looked at one cycle later
	task automatic status(input string what, input logic [8:0] exp);
		strobe(2, 36'h0);
		#1;
		check("status enable", 36'h1, {35'h0, bus_data_oe});
		check(what, {27'h0, exp}, bus_data_out);
	endtask
	// Counts, verdict and end of run
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Cut a hang short
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			err_count++;
			conclude();
		end
	end
	initial begin
		clk = 0; rstn = 0; clk_en = 1; dev_select = 1; slow = 0; printer_error = 0;
		{condition_out_write, data_out_write, condition_in_read, data_in_read} = 4'h0;
		bus_data_in = 36'h0; err_count = 0; n_tests = 0; cycles = 0;
		rows = '{{1'h0, 8'h9D, 7'h00}, {1'h1, 8'h79, 7'h41}, {1'h0, 8'hC7, 7'h40},
			{1'h0, 8'h50, 7'h00}, {1'h0, 8'h00, 7'h00}};
		repeat (6) @(posedge clk);
		check("reset outputs", 36'h0, {27'h0, bus_data_oe, char_valid, pi_request});
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		// Control words, then requests and status
		foreach (rows[i]) begin
			printer_error <= rows[i][15];
			strobe(0, {28'h0, rows[i][14:7]});
			repeat (4) @(posedge clk);
			#1;
			check("requests", {29'h0, rows[i][6:0]}, {29'h0, pi_request});
			status("status", rows[i][15:7]);
		end
		// Unaddressed control word and data-in read change nothing
		dev_select <= 1'b0;
		strobe(0, 36'hFF);
		dev_select <= 1'b1;
		strobe(3, 36'h0);
		@(posedge clk);
		#1;
		check("data-in drive", 36'h0, {35'h0, bus_data_oe});
		status("unaddressed", 9'h000);
		// Five characters to a slow printer
		slow <= 1'b1;
		strobe(0, 36'h2);
		model.got.delete();
		strobe(1, {7'h41, 7'h42, 7'h43, 7'h44, 7'h45, 1'h0});
		status("busy after data", 9'h082);
		for (int k = 0; k < 200 && pi_request !== 7'h02; k++) @(posedge clk);
		#1;
		check("done request", 36'h2, {29'h0, pi_request});
		check("char count", 36'h5, 36'(model.got.size()));
		for (int k = 0; k < 5; k++) check("char", 36'(7'h41 + k), {29'h0, model.got[k]});
		status("done after data", 9'h042);
		// Initialize in mid-transfer drops the rest
		strobe(1, {7'h51, 7'h52, 7'h53, 7'h54, 7'h55, 1'h0});
		repeat (5) @(posedge clk);
		strobe(0, 36'h480);
		repeat (2) @(posedge clk);
		n_got = model.got.size();
		repeat (30) @(posedge clk);
		check("chars after init", 36'(n_got), 36'(model.got.size()));
		check("init cut short", 36'h1, {35'h0, n_got < 10});
		status("after init", 9'h080);
		conclude();
	end
endmodule
